// ---- bus_master_model.sv ----
// Serial-bus master model issuing one holding-register request at a time.
// Assumes the bank answers exactly one cycle after the strobe edge.
module bus_master_model
(
  input  logic        clock,
  input  logic        reg_ack,
  input  logic [15:0] reg_rdata,
  input  logic [1:0]  reg_resp,
  output logic        reg_rd,
  output logic        reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
  end

  // One-cycle strobe, answer taken one edge later
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic [1:0] r);
    @(posedge clock);
    #1 {reg_rd, reg_wr, reg_addr, reg_wdata} = {rd, ~rd, a, d};
    @(posedge clock);
    // Released address and data lines show the inverse, so a stale value never matches by luck
    #1 {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
    r = (reg_ack === 1'b1) ? reg_resp : 2'bxx;
  endtask
endmodule // bus_master_model

// ---- feature_words.v ----
// Assembles the two read-only feature words from presence straps.
// Assumes straps are static levels after reset.
module feature_words
(
  input  wire        has_overload_prot,
  input  wire        has_short_delay_prot,
  input  wire        has_instant_prot,
  input  wire        has_ground_fault_prot,
  input  wire        has_maintenance_mode,
  input  wire        has_instant_override,
  input  wire        has_motor_prot,
  input  wire        four_pole_flag,
  input  wire        has_thermal_memory,
  input  wire        has_voltage_meter,
  input  wire        model_variant,
  input  wire        has_serial_bus_port,
  input  wire        has_aux_serial_module,
  input  wire        has_io_module,
  input  wire        has_relay_module,
  input  wire        has_zone_selectivity,
  input  wire        has_display,
  output wire [15:0] feature_one,
  output wire [15:0] feature_two
);

  // Unused bits read as zero, bit 6 included
  assign feature_one = {2'h0, model_variant, has_voltage_meter, 2'h0,
                        has_thermal_memory, four_pole_flag,
                        has_motor_prot, 1'b0, has_instant_override,
                        has_maintenance_mode,
                        has_ground_fault_prot, has_instant_prot,
                        has_short_delay_prot, has_overload_prot};
  assign feature_two = {10'h000, has_display, has_zone_selectivity,
                        has_relay_module, has_io_module,
                        has_aux_serial_module, has_serial_bus_port};

endmodule // feature_words

// ---- setpoint_asserts.sv ----
// Assertions on the setpoint register bank, watching its top ports only.
// Assumes one-cycle strobes and an answer exactly one cycle later.
`include "setpoint_defs.vh"

module setpoint_asserts
(
  input logic        clock,
  input logic        rst_b,
  input logic        reg_rd,
  input logic        reg_wr,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic        has_ground_fault_prot,
  input logic [15:0] reg_rdata,
  input logic        reg_ack,
  input logic [1:0]  reg_resp,
  input logic [15:0] access_key_value,
  input logic        thermal_memory_on,
  input logic        zsi_short_delay_on,
  input logic        zsi_ground_fault_on,
  input logic [1:0]  overload_waveform
);
  // ------------------------------------------------------------
  // Request shapes and checks
  // ------------------------------------------------------------
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence rd_at(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_at(logic [15:0] a);
    reg_wr && reg_addr == a;
  endsequence

  key_stored_a:
    assert property (wr_at(16'h0bb7) |=> ##1 access_key_value == $past(reg_wdata, 2)) else $error("key");
  group_fixed_a:
    assert property (rd_at(16'h0bb8) |=> reg_rdata == `RST_PROT_GROUP) else $error("group word");
  rated_field_a:
    assert property (rd_at(16'h0bb9) |=> reg_ack && reg_rdata[15:13] == 3'h0) else $error("rated");
  frame_field_a:
    assert property (rd_at(16'h0bba) |=> reg_rdata[15:3] == 13'h0) else $error("frame code");
  ro_refused_a:
    assert property (reg_wr && reg_addr inside {[16'h0bb9:16'h0bbc]} |=>
      reg_ack && reg_resp == `RESP_ILLEGAL_ACCESS) else $error("read-only write taken");
  thermal_write_a:
    assert property (wr_at(16'h0bbd) |=> ##1 thermal_memory_on == $past(reg_wdata[0], 2))
      else $error("thermal enable");
  zsi_both_a:
    assert property (zsi_short_delay_on && $past(has_ground_fault_prot) |-> zsi_ground_fault_on)
      else $error("zone ground fault missing");
  zsi_short_only_a:
    assert property (zsi_ground_fault_on |-> zsi_short_delay_on && $past(has_ground_fault_prot))
      else $error("zone ground fault wrong");
  waveform_write_a:
    assert property (wr_at(16'h0bbf) |=> ##1 overload_waveform == $past(reg_wdata[1:0], 2))
      else $error("waveform");
endmodule // setpoint_asserts

bind trip_unit_setpoint_registers setpoint_asserts u_setpoint_asserts (.clock, .rst_b, .reg_rd,
  .reg_wr, .reg_addr, .reg_wdata, .has_ground_fault_prot, .reg_rdata, .reg_ack, .reg_resp,
  .access_key_value, .thermal_memory_on, .zsi_short_delay_on, .zsi_ground_fault_on,
  .overload_waveform);

// ---- setpoint_defs.vh ----
// Constants for the trip unit setting and identification register bank.
// Assumes a holding-register port that presents 16-bit word addresses.
// Notes on behaviour
// - Access key write-only, resets zero, reads zero
// - Protection group word holds 0x01ff
// - Rated current read-only in bits 12..0
// - Frame size code read-only in bits 2..0
// - Feature word one bits 0..3 protections
// - Bits 4,5,7 maintenance, override, motor; 6 unused
// - Bit 8 four-pole, 9 thermal, 12 voltage, 13 variant
// - Feature word two bits 0..5 options
// - Thermal memory enable bit 0
// - Zone selectivity with ground fault: both releases
// - Without ground fault: short delay only
// - Overload waveform 2-bit field, default 2
`ifndef SETPOINT_DEFS_VH
`define SETPOINT_DEFS_VH

// ----------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------
`define ADDR_ACCESS_KEY      16'h0bb7
`define ADDR_PROT_GROUP      16'h0bb8
`define ADDR_RATED_CURRENT   16'h0bb9
`define ADDR_FRAME_SIZE      16'h0bba
`define ADDR_FEATURE_ONE     16'h0bbb
`define ADDR_FEATURE_TWO     16'h0bbc
`define ADDR_THERMAL_CTRL    16'h0bbd
`define ADDR_ZONE_CTRL       16'h0bbe
`define ADDR_WAVEFORM_CTRL   16'h0bbf

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define RST_ACCESS_KEY       16'h0000
`define RST_PROT_GROUP       16'h01ff
`define RST_THERMAL_CTRL     16'h0001
`define RST_ZONE_CTRL        16'h0000
`define RST_THERMAL_EN       1'b1
`define RST_ZONE_EN          1'b0
`define RST_WAVEFORM         2'h2
`define RATED_CURRENT_MASK   16'h1fff
`define FRAME_SIZE_MASK      16'h0007
`define WAVEFORM_MASK        16'h0003

// Answer codes of the holding-register port
`define RESP_OK              2'h0
`define RESP_ILLEGAL_ADDR    2'h1
`define RESP_ILLEGAL_ACCESS  2'h2

`endif

// ---- trip_unit_setpoint_registers.v ----
// Holding-register bank of trip unit settings and identification.
// Assumes the serial framing layer issues one-cycle read or write strobes
// with a word address, and takes the answer one cycle later.
`include "setpoint_defs.vh"

module trip_unit_setpoint_registers
#(
  parameter RATED_CURRENT_A = 16'h00fa,  // Plain default, strapped per build
  parameter FRAME_CODE      = 3'h1       // Arbitrary value, not a real code
)
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        has_overload_prot,
  input  wire        has_short_delay_prot,
  input  wire        has_instant_prot,
  input  wire        has_ground_fault_prot,
  input  wire        has_maintenance_mode,
  input  wire        has_instant_override,
  input  wire        has_motor_prot,
  input  wire        four_pole_flag,
  input  wire        has_thermal_memory,
  input  wire        has_voltage_meter,
  input  wire        model_variant,
  input  wire        has_serial_bus_port,
  input  wire        has_aux_serial_module,
  input  wire        has_io_module,
  input  wire        has_relay_module,
  input  wire        has_zone_selectivity,
  input  wire        has_display,
  output reg  [15:0] reg_rdata,
  output reg         reg_ack,
  output reg  [1:0]  reg_resp,
  output reg  [15:0] access_key_value,
  output reg         thermal_memory_on,
  output reg         zsi_short_delay_on,
  output reg         zsi_ground_fault_on,
  output reg  [1:0]  overload_waveform
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  reg        rst_meta_reg;
  reg        rst_sync_reg;

  // Asynchronous assert, synchronous release through two stages
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire       rst_sync_b = rst_sync_reg;

  // ----------------------------------------------------------------------
  // Stored registers
  // ----------------------------------------------------------------------
  reg [15:0] access_key_reg;
  reg [15:0] prot_group_reg;
  reg        thermal_reg;
  reg        zone_reg;
  reg [1:0]  waveform_reg;

  wire [15:0] feature_one;
  wire [15:0] feature_two;
  wire        zsi_sd;
  wire        zsi_gf;

  feature_words u_feature_words
  (
    .has_overload_prot     (has_overload_prot),
    .has_short_delay_prot  (has_short_delay_prot),
    .has_instant_prot      (has_instant_prot),
    .has_ground_fault_prot (has_ground_fault_prot),
    .has_maintenance_mode  (has_maintenance_mode),
    .has_instant_override  (has_instant_override),
    .has_motor_prot        (has_motor_prot),
    .four_pole_flag        (four_pole_flag),
    .has_thermal_memory    (has_thermal_memory),
    .has_voltage_meter     (has_voltage_meter),
    .model_variant         (model_variant),
    .has_serial_bus_port   (has_serial_bus_port),
    .has_aux_serial_module (has_aux_serial_module),
    .has_io_module         (has_io_module),
    .has_relay_module      (has_relay_module),
    .has_zone_selectivity  (has_zone_selectivity),
    .has_display           (has_display),
    .feature_one           (feature_one),
    .feature_two           (feature_two)
  );

  zone_select u_zone_select
  (
    .zone_selectivity_enable (zone_reg),
    .has_ground_fault_prot   (has_ground_fault_prot),
    .zsi_short_delay         (zsi_sd),
    .zsi_ground_fault        (zsi_gf)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  reg        hit;
  reg        read_only;
  reg [15:0] rd_value;

  // Read mux and access class; key reads back as zero
  always @*
  begin
    hit       = 1'b1;
    read_only = 1'b0;
    rd_value  = 16'h0000;
    if (reg_addr == `ADDR_ACCESS_KEY)
      rd_value = 16'h0000;
    else if (reg_addr == `ADDR_PROT_GROUP)
      rd_value = prot_group_reg;
    else if (reg_addr == `ADDR_RATED_CURRENT)
    begin
      rd_value  = RATED_CURRENT_A & `RATED_CURRENT_MASK;
      read_only = 1'b1;
    end
    else if (reg_addr == `ADDR_FRAME_SIZE)
    begin
      rd_value  = {13'h0000, FRAME_CODE} & `FRAME_SIZE_MASK;
      read_only = 1'b1;
    end
    else if (reg_addr == `ADDR_FEATURE_ONE)
    begin
      rd_value  = feature_one;
      read_only = 1'b1;
    end
    else if (reg_addr == `ADDR_FEATURE_TWO)
    begin
      rd_value  = feature_two;
      read_only = 1'b1;
    end
    else if (reg_addr == `ADDR_THERMAL_CTRL)
      rd_value = {15'h0000, thermal_reg};
    else if (reg_addr == `ADDR_ZONE_CTRL)
      rd_value = {15'h0000, zone_reg};
    else if (reg_addr == `ADDR_WAVEFORM_CTRL)
      rd_value = {14'h0000, waveform_reg};
    else
      hit = 1'b0;
  end

  wire wr_ok = reg_wr & hit & ~read_only;

  // ----------------------------------------------------------------------
  // Write selects
  // ----------------------------------------------------------------------
  // One select per writable word; refused and unmapped writes reach none
  wire       wr_key     = wr_ok & (reg_addr == `ADDR_ACCESS_KEY);
  wire       wr_group   = wr_ok & (reg_addr == `ADDR_PROT_GROUP);
  wire       wr_thermal = wr_ok & (reg_addr == `ADDR_THERMAL_CTRL);
  wire       wr_zone    = wr_ok & (reg_addr == `ADDR_ZONE_CTRL);
  wire       wr_wave    = wr_ok & (reg_addr == `ADDR_WAVEFORM_CTRL);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Key is kept for the framing layer and never read back
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      access_key_reg <= `RST_ACCESS_KEY;
    else if (wr_key)
      access_key_reg <= reg_wdata;
  end

  // Group word is writable but pinned, so a write only reloads it
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      prot_group_reg <= `RST_PROT_GROUP;
    else if (wr_group)
      prot_group_reg <= `RST_PROT_GROUP;
  end

  // Starts enabled, since clearing it is meant for repeated testing only
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      thermal_reg <= `RST_THERMAL_EN;
    else if (wr_thermal)
      thermal_reg <= reg_wdata[0];
  end

  // Zone selectivity starts switched off
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      zone_reg <= `RST_ZONE_EN;
    else if (wr_zone)
      zone_reg <= reg_wdata[0];
  end

  // Any 2-bit code is kept; only the default code has a meaning
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      waveform_reg <= `RST_WAVEFORM;
    else if (wr_wave)
      waveform_reg <= reg_wdata[1:0];
  end

  // ----------------------------------------------------------------------
  // Answer next values
  // ----------------------------------------------------------------------
  reg        ack_next;
  reg [15:0] rdata_next;
  reg [1:0]  resp_next;

  // Unmapped wins over refused; write answers carry no data
  always @*
  begin
    ack_next   = reg_rd | reg_wr;
    rdata_next = 16'h0000;
    resp_next  = `RESP_OK;
    if (reg_rd & hit)
      rdata_next = rd_value;
    if (!hit)
      resp_next = `RESP_ILLEGAL_ADDR;
    else if (reg_wr & read_only)
      resp_next = `RESP_ILLEGAL_ACCESS;
  end

  // ----------------------------------------------------------------------
  // Answers
  // ----------------------------------------------------------------------
  // Acknowledge stands one cycle per strobe
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_ack <= ack_next;
    end
  end

  // Read data; zero on writes so a stale word never leaks out
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_rdata <= rdata_next;
    end
  end

  // Answer code, valid while the acknowledge stands
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      reg_resp <= `RESP_OK;
    end
    else
    begin
      reg_resp <= resp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  // Lag the stored words by one cycle, traded for flop-only pins
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      access_key_value <= `RST_ACCESS_KEY;
    end
    else
    begin
      access_key_value <= access_key_reg;
    end
  end

  // Thermal memory enable for the overload release
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      thermal_memory_on <= `RST_THERMAL_EN;
    end
    else
    begin
      thermal_memory_on <= thermal_reg;
    end
  end

  // Short delay release always joins zone selectivity
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      zsi_short_delay_on <= 1'b0;
    end
    else
    begin
      zsi_short_delay_on <= zsi_sd;
    end
  end

  // Ground fault joins only when that protection is fitted
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      zsi_ground_fault_on <= 1'b0;
    end
    else
    begin
      zsi_ground_fault_on <= zsi_gf;
    end
  end

  // Overload release waveform code
  always @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      overload_waveform <= `RST_WAVEFORM;
    end
    else
    begin
      overload_waveform <= waveform_reg;
    end
  end

endmodule // trip_unit_setpoint_registers

// ---- trip_unit_setpoint_registers_bench.sv ----
// Self-checking bench for the setpoint register bank.
// Assumes the bus master model and the bound checker are compiled alongside.
`include "setpoint_defs.vh"

module trip_unit_setpoint_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic rd; logic [15:0] a, d, er; logic [1:0] es;} row_t;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [16:0] s     = 17'h0aaaa;  // Presence straps in port order
  logic        reg_rd, reg_wr, reg_ack, thermal_memory_on, zsi_short_delay_on, zsi_ground_fault_on;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, access_key_value, q;
  logic [1:0]  reg_resp, overload_waveform, r;
  int          error_cnt = 0;
  int          checked   = 0;
  // ------------------------------------------------------------
  // Ordinary cases: rd, address, write data, expected data, expected answer
  // ------------------------------------------------------------
  row_t rows[] = '{
    '{1'b1,16'h0bb7,16'h0,16'h0,2'h0}, '{1'b0,16'h0bb7,16'h5a5a,16'h0,2'h0},
    '{1'b1,16'h0bb7,16'h0,16'h0,2'h0}, '{1'b1,16'h0bb8,16'h0,16'h01ff,2'h0},
    '{1'b0,16'h0bb8,16'h1234,16'h0,2'h0}, '{1'b1,16'h0bb8,16'h0,16'h01ff,2'h0},
    '{1'b1,16'h0bb9,16'h0,16'h00fa,2'h0}, '{1'b1,16'h0bba,16'h0,16'h0001,2'h0},
    '{1'b0,16'h0bb9,16'hffff,16'h0,2'h2}, '{1'b0,16'h0bba,16'hffff,16'h0,2'h2},
    '{1'b0,16'h0bbb,16'hffff,16'h0,2'h2}, '{1'b0,16'h0bbc,16'hffff,16'h0,2'h2},
    '{1'b1,16'h0bb9,16'h0,16'h00fa,2'h0}, '{1'b1,16'h0bba,16'h0,16'h0001,2'h0},
    '{1'b1,16'h0bb6,16'h0,16'h0,2'h1}, '{1'b1,16'h0bc0,16'h0,16'h0,2'h1},
    '{1'b0,16'h0bbf,16'h1,16'h0,2'h0}, '{1'b1,16'h0bbf,16'h0,16'h1,2'h0},
    '{1'b0,16'h0bbf,16'h3,16'h0,2'h0}, '{1'b1,16'h0bbf,16'h0,16'h3,2'h0},
    '{1'b0,16'h0bbf,16'h0,16'h0,2'h0}, '{1'b1,16'h0bbf,16'h0,16'h0,2'h0},
    '{1'b0,16'h0bbf,16'h2,16'h0,2'h0}, '{1'b1,16'h0bbf,16'h0,16'h2,2'h0},
    '{1'b0,16'h0bbd,16'h0,16'h0,2'h0}, '{1'b1,16'h0bbd,16'h0,16'h0,2'h0},
    '{1'b0,16'h0bbd,16'h1,16'h0,2'h0}, '{1'b1,16'h0bbd,16'h0,16'h1,2'h0},
    '{1'b0,16'h0bbe,16'h1,16'h0,2'h0}, '{1'b1,16'h0bbe,16'h0,16'h1,2'h0},
    '{1'b0,16'h0bbe,16'h0,16'h0,2'h0}, '{1'b1,16'h0bbe,16'h0,16'h0,2'h0}};

  always #20 clock = ~clock;

  trip_unit_setpoint_registers u_trip_unit_setpoint_registers (.clock, .rst_b, .reg_rd,
    .reg_wr, .reg_addr, .reg_wdata, .has_overload_prot(s[0]), .has_short_delay_prot(s[1]),
    .has_instant_prot(s[2]), .has_ground_fault_prot(s[3]), .has_maintenance_mode(s[4]),
    .has_instant_override(s[5]), .has_motor_prot(s[6]), .four_pole_flag(s[7]),
    .has_thermal_memory(s[8]), .has_voltage_meter(s[9]), .model_variant(s[10]),
    .has_serial_bus_port(s[11]), .has_aux_serial_module(s[12]), .has_io_module(s[13]),
    .has_relay_module(s[14]), .has_zone_selectivity(s[15]), .has_display(s[16]),
    .reg_rdata, .reg_ack, .reg_resp, .access_key_value, .thermal_memory_on,
    .zsi_short_delay_on, .zsi_ground_fault_on, .overload_waveform);
  bus_master_model u_bus_master_model (.clock, .reg_ack, .reg_rdata, .reg_resp, .reg_rd,
    .reg_wr, .reg_addr, .reg_wdata);

  task automatic go(input logic rd, input logic [15:0] a, input logic [15:0] d);
    u_bus_master_model.xfer(rd, a, d, q, r);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Five edges low, then two edges for the synchroniser to let go
  task automatic rst_seq;
    rst_b = 1'b0;
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is under a hundred cycles; this leaves a wide margin
  initial
  begin
    #100000;
    error_cnt++;
    results();
  end

  initial
  begin
    rst_seq();
    chk("key out", `RST_ACCESS_KEY, access_key_value);
    chk("thermal", `RST_THERMAL_CTRL, {15'h0, thermal_memory_on});
    chk("waveform", {14'h0, `RST_WAVEFORM}, {14'h0, overload_waveform});
    foreach (rows[i])
    begin
      go(rows[i].rd, rows[i].a, rows[i].d);
      chk("rdata", rows[i].er, q);
      chk("resp", {14'h0, rows[i].es}, {14'h0, r});
    end
    chk("key out", 16'h5a5a, access_key_value);
    // Complementary strap patterns catch stuck and swapped bits
    for (int i = 0; i < 2; i++)
    begin
      s = i ? 17'h15555 : 17'h0aaaa;
      go(1'b1, 16'h0bbb, 16'h0);
      chk("feature one", {2'b0, s[10:9], 2'b0, s[8:6], 1'b0, s[5:0]}, q);
      go(1'b1, 16'h0bbc, 16'h0);
      chk("feature two", {10'h0, s[16:11]}, q);
    end
    s[3] = 1'b1;
    go(1'b0, 16'h0bbe, 16'h1);
    @(posedge clock);
    #1 chk("zone pair", 16'h3, {14'h0, zsi_short_delay_on, zsi_ground_fault_on});
    s[3] = 1'b0;
    @(posedge clock);
    #1 chk("zone pair", 16'h2, {14'h0, zsi_short_delay_on, zsi_ground_fault_on});
    // Reset in mid-run must restore the documented defaults
    go(1'b0, 16'h0bbf, 16'h1);
    rst_seq();
    chk("waveform", {14'h0, `RST_WAVEFORM}, {14'h0, overload_waveform});
    chk("zone pair", 16'h0, {14'h0, zsi_short_delay_on, zsi_ground_fault_on});
    go(1'b1, 16'h0bbf, 16'h0);
    chk("waveform rd", 16'h2, q);
    results();
  end
endmodule // trip_unit_setpoint_registers_bench

// ---- zone_select.v ----
// Decides which releases take part in zone selectivity.
// Assumes enable and ground-fault presence are registered levels.
module zone_select
(
  input  wire zone_selectivity_enable,
  input  wire has_ground_fault_prot,
  output wire zsi_short_delay,
  output wire zsi_ground_fault
);

  // Short delay always joins; ground fault only when fitted
  assign zsi_short_delay  = zone_selectivity_enable;
  assign zsi_ground_fault = zone_selectivity_enable & has_ground_fault_prot;

endmodule // zone_select
